// ---- rtl/acc_map.svh ----
// offsets, field positions, reset values and timing counts of the controller
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH

// load flag positions, in steering order
`define LD_CTRL        0
`define LD_INTV        1
`define LD_RXR         2
`define LD_TXR         3
`define LD_ALL         4'hf

// control register fields
`define CTRL_LEN_LSB   0
`define CTRL_LEN_MSB   1
`define CTRL_ODD       2
`define CTRL_PAR_EN    3
`define CTRL_TEST      4
`define CTRL_STOP2     5
`define CTRL_RESET     8'h03

// rate register fields
`define RATE_PRE_BIT   10
`define RATE_PRE_SHIFT 3
`define RATE_RESET     11'h001

`define INTV_RESET     8'h01

// configuration write widths, in bits
`define WR_LEN_BYTE    4'h8
`define WR_LEN_RATE    4'hb
`define WR_LEN_BOTH    4'hc

// interval timer prescale terminal counts; one step takes the count plus one internal clock cycles
`define TMR_DIV_NORM   6'h3f
`define TMR_DIV_TEST   6'h01

`define CHAR_LEN_MIN   4'h5

`endif

// ---- rtl/acc_pkg.sv ----
// state types of the serial controller
package acc_pkg;

   typedef enum logic [2:0]
   {
      TX_IDLE   = 3'b000,
      TX_START  = 3'b001,
      TX_DATA   = 3'b010,
      TX_PARITY = 3'b011,
      TX_STOP   = 3'b100,
      TX_BREAK  = 3'b101
   } tx_state_t;

   typedef enum logic [2:0]
   {
      RX_IDLE   = 3'b000,
      RX_START  = 3'b001,
      RX_DATA   = 3'b010,
      RX_PARITY = 3'b011,
      RX_STOP   = 3'b100,
      RX_HOLD   = 3'b101
   } rx_state_t;

endpackage

// ---- rtl/bit_timer.sv ----
// bit-time tick generator for one direction of the serial line
`timescale 1ns/1ps
`include "acc_map.svh"

module bit_timer
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        restart,
   input  wire logic        half,
   input  wire logic [10:0] rate,
   output logic             tick
);

   logic [14:0] half_len;
   logic [14:0] full_len;
   logic [14:0] cnt_q;

   // half bit = count * prescale, full bit = twice that
   always_comb
   begin
      half_len = rate[`RATE_PRE_BIT] ?
                 {2'b00, rate[9:0], 3'b000} : {5'b00000, rate[9:0]};
      if (half_len == 15'h0000)
      begin
         half_len = 15'h0001;
      end
      full_len = {half_len[13:0], 1'b0};
   end

   // tick lands exactly one period after restart, then every full bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_q <= 15'h0000;
         tick  <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (restart)
         begin
            cnt_q <= (half ? half_len : full_len) - 15'h0001;
         end
         else if (cnt_q == 15'h0000)
         begin
            tick  <= 1'b1;
            cnt_q <= full_len - 15'h0001;
         end
         else
         begin
            cnt_q <= cnt_q - 15'h0001;
         end
      end
   end

endmodule

// ---- rtl/async_serial_rx_break_timer.sv ----
// serial controller core: break, termination, receiver, interval timer
`timescale 1ns/1ps
`include "acc_map.svh"

module async_serial_rx_break_timer
   import acc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        reset_cmd,
   input  wire logic [3:0]  load_flag_set,
   input  wire logic        cfg_wr,
   input  wire logic [3:0]  cfg_len,
   input  wire logic [11:0] cfg_data,
   input  wire logic        break_request_bit,
   input  wire logic        request_to_send_ctrl,
   input  wire logic        rx_loaded_clr,
   input  wire logic        timer_flags_clr,
   input  wire logic        serial_rx_in,
   input  wire logic        cts_n,
   output logic             serial_tx_out,
   output logic             rts_n,
   output logic             wr_refused,
   output logic             tx_buffer_empty_flag,
   output logic             tx_shifter_empty_flag,
   output logic [7:0]       rx_data,
   output logic             rx_buffer_loaded_flag,
   output logic             rx_start_detected_flag,
   output logic             rx_first_bit_flag,
   output logic             rx_framing_error_flag,
   output logic             rx_overrun_flag,
   output logic             rx_parity_error_flag,
   output logic             timer_elapsed_flag,
   output logic             timer_missed_flag,
   output logic             control_load_flag,
   output logic             interval_load_flag,
   output logic             rx_rate_load_flag,
   output logic             tx_rate_load_flag
);

   // ***********************************************************
   // shared decoding
   // ***********************************************************

   function automatic logic [7:0] char_mask(input logic [3:0] len);
      char_mask = 8'hff >> (4'h8 - len);
   endfunction

   // ***********************************************************
   // pin synchronisers
   // ***********************************************************

   logic rx_meta_q;
   logic rx_sync_q;
   logic rx_prev_q;
   logic cts_meta_q;
   logic cts_sync_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rx_meta_q  <= 1'b1;
         rx_sync_q  <= 1'b1;
         rx_prev_q  <= 1'b1;
         cts_meta_q <= 1'b1;
         cts_sync_q <= 1'b1;
      end
      else
      begin
         rx_meta_q  <= serial_rx_in;
         rx_sync_q  <= rx_meta_q;
         rx_prev_q  <= rx_sync_q;
         cts_meta_q <= cts_n;
         cts_sync_q <= cts_meta_q;
      end
   end

   // ***********************************************************
   // configuration registers and load flags
   // ***********************************************************

   logic [3:0]  ld_q;
   logic [7:0]  ctrl_q;
   logic [7:0]  intv_q;
   logic [10:0] rx_rate_q;
   logic [10:0] tx_rate_q;
   logic [3:0]  char_len;
   logic        buf_wr;
   tx_state_t   tx_state_q;

   assign char_len = `CHAR_LEN_MIN +
                     {2'b00, ctrl_q[`CTRL_LEN_MSB:`CTRL_LEN_LSB]};

   // with every load flag clear a write targets the transmit buffer
   assign buf_wr = cfg_wr && (ld_q == 4'h0);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ld_q      <= `LD_ALL;
         ctrl_q    <= `CTRL_RESET;
         intv_q    <= `INTV_RESET;
         rx_rate_q <= `RATE_RESET;
         tx_rate_q <= `RATE_RESET;
      end
      else if (reset_cmd)
      begin
         ld_q <= `LD_ALL;
      end
      else
      begin
         ld_q <= ld_q | load_flag_set;
         if (cfg_wr && ld_q[`LD_CTRL])
         begin
            ctrl_q <= cfg_data[7:0];
            if (cfg_len >= `WR_LEN_BYTE)
            begin
               ld_q[`LD_CTRL] <= 1'b0;
            end
         end
         else if (cfg_wr && ld_q[`LD_INTV])
         begin
            intv_q <= cfg_data[7:0];
            if (cfg_len >= `WR_LEN_BYTE)
            begin
               ld_q[`LD_INTV] <= 1'b0;
            end
         end
         else if (cfg_wr && ld_q[`LD_RXR])
         begin
            rx_rate_q <= cfg_data[10:0];
            if (cfg_len >= `WR_LEN_RATE)
            begin
               ld_q[`LD_RXR] <= 1'b0;
            end
            if (cfg_len >= `WR_LEN_BOTH && ld_q[`LD_TXR])
            begin
               tx_rate_q     <= cfg_data[10:0];
               ld_q[`LD_TXR] <= 1'b0;
            end
         end
         else if (cfg_wr && ld_q[`LD_TXR])
         begin
            tx_rate_q <= cfg_data[10:0];
            if (cfg_len >= `WR_LEN_BOTH)
            begin
               ld_q[`LD_TXR] <= 1'b0;
            end
         end
      end
   end

   // ***********************************************************
   // transmitter with break and termination
   // ***********************************************************

   logic       tx_tick;
   logic       tx_go;
   logic       tx_en;
   logic       tx_buffer_empty_flag_q;
   logic       tx_shifter_empty_flag_q;
   logic [7:0] tx_buf_q;
   logic [7:0] tx_sh_q;
   logic [3:0] tx_cnt_q;
   logic       tx_par_q;
   logic       tx_stop2_q;
   logic       tx_out_q;
   logic       rts_n_q;
   logic       refused_q;

   assign tx_en = !rts_n_q && !cts_sync_q;
   // a buffer loaded before a break starts goes out first; one written in the cycle the break starts waits until it ends
   assign tx_go = (tx_state_q == TX_IDLE) && !tx_buffer_empty_flag_q && tx_en;

   bit_timer tx_timer
   (
      .clk     (clk),
      .rst     (rst),
      .restart (tx_go),
      .half    (1'b0),
      .rate    (tx_rate_q),
      .tick    (tx_tick)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tx_state_q <= TX_IDLE;
         tx_buffer_empty_flag_q     <= 1'b1;
         tx_shifter_empty_flag_q     <= 1'b1;
         tx_buf_q   <= 8'h00;
         tx_sh_q    <= 8'h00;
         tx_cnt_q   <= 4'h0;
         tx_par_q   <= 1'b0;
         tx_stop2_q <= 1'b0;
         tx_out_q   <= 1'b1;
         refused_q  <= 1'b0;
      end
      else if (reset_cmd)
      begin
         tx_state_q <= TX_IDLE;
         tx_buffer_empty_flag_q     <= 1'b1;
         tx_shifter_empty_flag_q     <= 1'b1;
         tx_out_q   <= 1'b1;
         refused_q  <= 1'b0;
      end
      else
      begin
         // no buffer loads while the line is held in break
         refused_q <= buf_wr && (tx_state_q == TX_BREAK);
         if (buf_wr && tx_state_q != TX_BREAK)
         begin
            tx_buf_q <= cfg_data[7:0] & char_mask(char_len);
            tx_buffer_empty_flag_q   <= 1'b0;
         end
         unique case (tx_state_q)
            TX_IDLE:
            begin
               tx_out_q <= 1'b1;
               if (tx_go)
               begin
                  tx_sh_q    <= tx_buf_q;
                  tx_par_q   <= ^tx_buf_q ^ ctrl_q[`CTRL_ODD];
                  tx_buffer_empty_flag_q     <= 1'b1;
                  tx_shifter_empty_flag_q     <= 1'b0;
                  tx_out_q   <= 1'b0;
                  tx_state_q <= TX_START;
               end
               else if (tx_buffer_empty_flag_q && tx_shifter_empty_flag_q && !cts_sync_q &&
                        break_request_bit)
               begin
                  tx_out_q   <= 1'b0;
                  tx_state_q <= TX_BREAK;
               end
            end
            TX_START, TX_DATA:
            begin
               if (tx_tick)
               begin
                  if (tx_state_q == TX_DATA && tx_cnt_q == char_len)
                  begin
                     tx_out_q   <= ctrl_q[`CTRL_PAR_EN] ? tx_par_q : 1'b1;
                     tx_stop2_q <= 1'b0;
                     tx_state_q <= ctrl_q[`CTRL_PAR_EN] ? TX_PARITY
                                                         : TX_STOP;
                  end
                  else
                  begin
                     tx_out_q   <= tx_sh_q[0];
                     tx_sh_q    <= {1'b0, tx_sh_q[7:1]};
                     tx_cnt_q   <= (tx_state_q == TX_START) ? 4'h1
                                                            : tx_cnt_q + 4'h1;
                     tx_state_q <= TX_DATA;
                  end
               end
            end
            TX_PARITY:
            begin
               if (tx_tick)
               begin
                  tx_out_q   <= 1'b1;
                  tx_state_q <= TX_STOP;
               end
            end
            TX_STOP:
            begin
               if (tx_tick)
               begin
                  if (ctrl_q[`CTRL_STOP2] && !tx_stop2_q)
                  begin
                     tx_stop2_q <= 1'b1;
                  end
                  else
                  begin
                     tx_shifter_empty_flag_q     <= 1'b1;
                     tx_state_q <= TX_IDLE;
                  end
               end
            end
            TX_BREAK:
            begin
               if (!break_request_bit)
               begin
                  tx_out_q   <= 1'b1;
                  tx_state_q <= TX_IDLE;
               end
            end
            default:
            begin
               tx_state_q <= TX_IDLE;
            end
         endcase
      end
   end

   // drop only when buffer and shifter are empty and no break runs
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rts_n_q <= 1'b1;
      end
      else if (reset_cmd)
      begin
         rts_n_q <= 1'b1;
      end
      else if (request_to_send_ctrl)
      begin
         rts_n_q <= 1'b0;
      end
      else if (tx_buffer_empty_flag_q && tx_shifter_empty_flag_q && tx_state_q == TX_IDLE &&
               !break_request_bit)
      begin
         rts_n_q <= 1'b1;
      end
   end

   // ***********************************************************
   // receiver
   // ***********************************************************

   rx_state_t  rx_state_q;
   logic       rx_tick;
   logic       rx_fall;
   logic       rx_go;
   logic [7:0] rx_sh_q;
   logic [7:0] rx_char;
   logic [3:0] rx_cnt_q;
   logic       rx_pbit_q;
   logic [7:0] rx_data_q;
   logic       rx_buffer_loaded_flag_q;
   logic       rx_start_detected_flag_q;
   logic       rx_first_bit_flag_q;
   logic       rx_framing_error_flag_q;
   logic       rx_overrun_flag_q;
   logic       rx_parity_error_flag_q;

   assign rx_fall = rx_prev_q && !rx_sync_q;
   assign rx_go   = (rx_state_q == RX_IDLE) && rx_fall;
   assign rx_char = (rx_sh_q >> (4'h8 - char_len)) & char_mask(char_len);

   bit_timer rx_timer
   (
      .clk     (clk),
      .rst     (rst),
      .restart (rx_go),
      .half    (1'b1),
      .rate    (rx_rate_q),
      .tick    (rx_tick)
   );

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rx_state_q <= RX_IDLE;
         rx_sh_q    <= 8'h00;
         rx_cnt_q   <= 4'h0;
         rx_pbit_q  <= 1'b0;
         rx_data_q  <= 8'h00;
         rx_buffer_loaded_flag_q     <= 1'b0;
         rx_start_detected_flag_q     <= 1'b0;
         rx_first_bit_flag_q     <= 1'b0;
         rx_framing_error_flag_q     <= 1'b0;
         rx_overrun_flag_q    <= 1'b0;
         rx_parity_error_flag_q     <= 1'b0;
      end
      else if (reset_cmd)
      begin
         rx_state_q <= RX_IDLE;
         rx_buffer_loaded_flag_q     <= 1'b0;
         rx_start_detected_flag_q     <= 1'b0;
         rx_first_bit_flag_q     <= 1'b0;
      end
      else
      begin
         if (rx_loaded_clr)
         begin
            rx_buffer_loaded_flag_q <= 1'b0;
         end
         unique case (rx_state_q)
            RX_IDLE:
            begin
               if (rx_go)
               begin
                  rx_state_q <= RX_START;
               end
            end
            RX_START:
            begin
               if (rx_tick)
               begin
                  rx_cnt_q   <= 4'h0;
                  rx_start_detected_flag_q     <= !rx_sync_q;
                  rx_state_q <= rx_sync_q ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA:
            begin
               if (rx_tick)
               begin
                  rx_sh_q  <= {rx_sync_q, rx_sh_q[7:1]};
                  rx_first_bit_flag_q   <= 1'b1;
                  rx_cnt_q <= rx_cnt_q + 4'h1;
                  if (rx_cnt_q + 4'h1 == char_len)
                  begin
                     rx_state_q <= ctrl_q[`CTRL_PAR_EN] ? RX_PARITY
                                                         : RX_STOP;
                  end
               end
            end
            RX_PARITY:
            begin
               if (rx_tick)
               begin
                  rx_pbit_q  <= rx_sync_q;
                  rx_state_q <= RX_STOP;
               end
            end
            RX_STOP:
            begin
               if (rx_tick)
               begin
                  // a new character wins over a host clear in this cycle
                  rx_data_q <= rx_char;
                  rx_buffer_loaded_flag_q    <= 1'b1;
                  rx_overrun_flag_q   <= rx_buffer_loaded_flag_q && !rx_loaded_clr;
                  rx_parity_error_flag_q    <= ctrl_q[`CTRL_PAR_EN] &&
                               (^rx_char ^ rx_pbit_q ^ ctrl_q[`CTRL_ODD]);
                  rx_start_detected_flag_q    <= 1'b0;
                  rx_first_bit_flag_q    <= 1'b0;
                  rx_framing_error_flag_q    <= !rx_sync_q;
                  rx_state_q <= rx_sync_q ? RX_IDLE : RX_HOLD;
               end
            end
            RX_HOLD:
            begin
               if (rx_sync_q)
               begin
                  rx_state_q <= RX_IDLE;
               end
            end
            default:
            begin
               rx_state_q <= RX_IDLE;
            end
         endcase
      end
   end

   // ***********************************************************
   // interval timer
   // ***********************************************************

   logic [7:0] tmr_q;
   logic [5:0] pre_q;
   logic       interval_load_flag_prev_q;
   logic       interval_load_flag_fall;
   logic       tmr_dec;
   logic       elp_q;
   logic       terr_q;

   assign interval_load_flag_fall = interval_load_flag_prev_q && !ld_q[`LD_INTV];
   assign tmr_dec   = pre_q == (ctrl_q[`CTRL_TEST] ? `TMR_DIV_TEST
                                                   : `TMR_DIV_NORM);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         interval_load_flag_prev_q <= 1'b1;
      end
      else
      begin
         interval_load_flag_prev_q <= ld_q[`LD_INTV];
      end
   end

   // the timer holds still while a new interval is awaited
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tmr_q  <= 8'h00;
         pre_q  <= 6'h00;
         elp_q  <= 1'b0;
         terr_q <= 1'b0;
      end
      else if (reset_cmd)
      begin
         elp_q  <= 1'b0;
         terr_q <= 1'b0;
         pre_q  <= 6'h00;
      end
      else
      begin
         if (timer_flags_clr)
         begin
            elp_q  <= 1'b0;
            terr_q <= 1'b0;
         end
         if (interval_load_flag_fall)
         begin
            tmr_q <= intv_q;
            pre_q <= 6'h00;
         end
         else if (!ld_q[`LD_INTV])
         begin
            pre_q <= tmr_dec ? 6'h00 : pre_q + 6'h01;
            if (tmr_dec)
            begin
               if (tmr_q <= 8'h01)
               begin
                  tmr_q <= intv_q;
                  elp_q <= 1'b1;
                  if (elp_q && !timer_flags_clr)
                  begin
                     terr_q <= 1'b1;
                  end
               end
               else
               begin
                  tmr_q <= tmr_q - 8'h01;
               end
            end
         end
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************

   assign serial_tx_out          = tx_out_q;
   assign rts_n                  = rts_n_q;
   assign wr_refused             = refused_q;
   assign tx_buffer_empty_flag   = tx_buffer_empty_flag_q;
   assign tx_shifter_empty_flag  = tx_shifter_empty_flag_q;
   assign rx_data                = rx_data_q;
   assign rx_buffer_loaded_flag  = rx_buffer_loaded_flag_q;
   assign rx_start_detected_flag = rx_start_detected_flag_q;
   assign rx_first_bit_flag      = rx_first_bit_flag_q;
   assign rx_framing_error_flag  = rx_framing_error_flag_q;
   assign rx_overrun_flag        = rx_overrun_flag_q;
   assign rx_parity_error_flag   = rx_parity_error_flag_q;
   assign timer_elapsed_flag     = elp_q;
   assign timer_missed_flag      = terr_q;
   assign control_load_flag      = ld_q[`LD_CTRL];
   assign interval_load_flag     = ld_q[`LD_INTV];
   assign rx_rate_load_flag      = ld_q[`LD_RXR];
   assign tx_rate_load_flag      = ld_q[`LD_TXR];

endmodule

// ---- verif/acc_props.sv ----
// concurrent checks on the serial controller core ports
`timescale 1ns/1ps
module acc_props
(
   input wire logic clk, rst, reset_cmd, cfg_wr, break_request_bit,
   input wire logic serial_tx_out, wr_refused, tx_buffer_empty_flag,
   input wire logic tx_shifter_empty_flag, rx_buffer_loaded_flag,
   input wire logic rx_start_detected_flag, rx_first_bit_flag,
   input wire logic timer_elapsed_flag, timer_missed_flag,
   input wire logic control_load_flag, interval_load_flag,
   input wire logic rx_rate_load_flag, tx_rate_load_flag,
   input wire logic [3:0] cfg_len, load_flag_set
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_brk_on;
      break_request_bit && tx_shifter_empty_flag && !serial_tx_out;
   endsequence
   AST_BRK_HOLD: assert property (s_brk_on ##0 !reset_cmd |=>
      !serial_tx_out) else $error("break not held");
   AST_BRK_END: assert property ($fell(break_request_bit) &&
      tx_buffer_empty_flag && tx_shifter_empty_flag && !reset_cmd
      |=> serial_tx_out) else $error("break not ended");
   AST_IDLE: assert property (tx_shifter_empty_flag &&
      !break_request_bit && !$past(break_request_bit) |-> serial_tx_out)
      else $error("idle line not high");
   AST_REFUSE: assert property (wr_refused |->
      $past(cfg_wr && break_request_bit)) else $error("bad refusal");
   AST_CTRL_LD: assert property (cfg_wr && control_load_flag &&
      cfg_len == 4'h8 && !reset_cmd && !load_flag_set[0]
      |=> !control_load_flag) else $error("control flag kept");
   AST_RATES: assert property (cfg_wr && cfg_len == 4'hc &&
      !reset_cmd && load_flag_set == 4'h0 && !control_load_flag &&
      !interval_load_flag && rx_rate_load_flag && tx_rate_load_flag
      |=> !rx_rate_load_flag && !tx_rate_load_flag)
      else $error("rate flags kept");
   AST_RST_CMD: assert property (reset_cmd |=>
      control_load_flag && interval_load_flag && rx_rate_load_flag &&
      tx_rate_load_flag && !timer_elapsed_flag && !timer_missed_flag &&
      !rx_buffer_loaded_flag) else $error("reset command incomplete");
   AST_RX_DONE: assert property ($rose(rx_buffer_loaded_flag) |->
      !rx_start_detected_flag && !rx_first_bit_flag)
      else $error("detect flags left set");
   AST_FIRST_BIT: assert property ($rose(rx_first_bit_flag) |->
      rx_start_detected_flag) else $error("first bit before start");
   AST_MISSED: assert property ($rose(timer_missed_flag) |->
      $past(timer_elapsed_flag)) else $error("missed without elapsed");
endmodule
bind async_serial_rx_break_timer acc_props u_props (.*);

// ---- verif/serial_peer.sv ----
// far-side line model feeding frames to the receiver
`timescale 1ns/1ps
module serial_peer
#(
   parameter int BIT_CYC = 8
)
(
   input  wire logic clk,
   output logic      line
);
   initial line = 1'h1;
   task automatic send(input logic [7:0] ch, input logic stop,
                       input logic [1:0] par);
      logic [10:0] f;
      // par[1] puts par[0] after the data, else the line idles one bit
      f = par[1] ? {stop, par[0], ch, 1'h0} : {1'h1, stop, ch, 1'h0};
      for (int i = 0; i < 11; i++)
      begin
         line <= f[i];
         repeat (BIT_CYC) @(posedge clk);
      end
      // pull-up takes the released line high
      line <= 1'h1;
      repeat (2 * BIT_CYC) @(posedge clk);
   endtask
   task automatic glitch(input int n);
      line <= 1'h0;
      repeat (n) @(posedge clk);
      line <= 1'h1;
      repeat (4 * BIT_CYC) @(posedge clk);
   endtask
endmodule

// ---- verif/async_serial_rx_break_timer_tb.sv ----
// self-checking bench for the serial controller core
`timescale 1ns/1ps
module async_serial_rx_break_timer_tb;
   logic clk, rst, reset_cmd, cfg_wr, break_request_bit, cts_n;
   logic request_to_send_ctrl, rx_loaded_clr, timer_flags_clr;
   logic serial_rx_in, serial_tx_out, rts_n, wr_refused;
   logic tx_buffer_empty_flag, tx_shifter_empty_flag, rx_buffer_loaded_flag;
   logic rx_start_detected_flag, rx_first_bit_flag, rx_framing_error_flag;
   logic rx_overrun_flag, rx_parity_error_flag, timer_elapsed_flag;
   logic timer_missed_flag, control_load_flag, interval_load_flag;
   logic rx_rate_load_flag, tx_rate_load_flag;
   logic [3:0]  load_flag_set, cfg_len;
   logic [11:0] cfg_data;
   logic [7:0]  rx_data;
   logic [9:0]  exp_q[$];
   int          fail_count, comparisons;
   async_serial_rx_break_timer DUT (.*);
   serial_peer peer (.clk(clk), .line(serial_rx_in));
   initial
   begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [3:0] len, input logic [11:0] d);
      @(posedge clk);
      cfg_len <= len;
      cfg_data <= d;
      cfg_wr <= 1'h1;
      @(posedge clk);
      cfg_wr <= 1'h0;
   endtask
   // bit time 8 cycles: count 4, prescale 1
   task automatic cfg_all();
      wr(4'h8, 12'h003);
      wr(4'h8, 12'h002);
      wr(4'hc, 12'h004);
      @(posedge clk);
      check({8'h0, control_load_flag, interval_load_flag, rx_rate_load_flag,
         tx_rate_load_flag}, 12'h0);
   endtask
   always @(posedge clk)
      if (rx_buffer_loaded_flag === 1'h1 && rx_loaded_clr === 1'h0)
      begin
         check({1'h0, rx_overrun_flag, rx_parity_error_flag,
            rx_framing_error_flag, rx_data},
            {2'h0, exp_q.pop_front()});
         rx_loaded_clr <= 1'h1;
      end
      else
         rx_loaded_clr <= 1'h0;
   initial
   begin
      repeat (5000) @(posedge clk);
      fail_count++;
      final_report();
   end
   initial
   begin
      logic [7:0] ch;
      {rst, cts_n} = 2'h3;
      {reset_cmd, cfg_wr, break_request_bit, request_to_send_ctrl} = 4'h0;
      {timer_flags_clr, load_flag_set} = 5'h0;
      cfg_len = 4'h0;
      cfg_data = 12'h0;
      void'($urandom(81593));
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      cfg_all();
      repeat (108) @(posedge clk);
      check({11'h0, timer_elapsed_flag}, 12'h0);
      repeat (30) @(posedge clk);
      check({11'h0, timer_elapsed_flag}, 12'h1);
      timer_flags_clr <= 1'h1;
      @(posedge clk);
      timer_flags_clr <= 1'h0;
      repeat (128) @(posedge clk);
      check({10'h0, timer_elapsed_flag, timer_missed_flag}, 12'h2);
      repeat (128) @(posedge clk);
      check({11'h0, timer_missed_flag}, 12'h1);
      reset_cmd <= 1'h1;
      @(posedge clk);
      reset_cmd <= 1'h0;
      @(posedge clk);
      check({9'h0, timer_elapsed_flag, timer_missed_flag,
         interval_load_flag}, 12'h1);
      $display("timer test done");
      cfg_all();
      for (int i = 0; i < 4; i++)
      begin
         ch = 8'($urandom);
         exp_q.push_back({1'h0, i == 3, ch});
         peer.send(ch, i != 3, 2'h0);
      end
      peer.glitch(2);
      check({11'h0, rx_start_detected_flag}, 12'h0);
      check(12'(exp_q.size()), 12'h0);
      // odd parity, eight bits; second character carries a bad parity bit
      load_flag_set <= 4'h1;
      @(posedge clk);
      load_flag_set <= 4'h0;
      wr(4'h8, 12'h00f);
      for (int i = 0; i < 2; i++)
      begin
         ch = 8'($urandom);
         exp_q.push_back({i == 1, 1'h0, ch});
         peer.send(ch, 1'h1, {1'h1, ^ch ^ (i == 0)});
      end
      check(12'(exp_q.size()), 12'h0);
      $display("receive test done");
      cts_n <= 1'h0;
      request_to_send_ctrl <= 1'h1;
      wr(4'h8, 12'(8'($urandom)));
      break_request_bit <= 1'h1;
      repeat (4) @(posedge clk);
      check({11'h0, tx_shifter_empty_flag}, 12'h0);
      for (int i = 0; i < 200 && tx_shifter_empty_flag !== 1'h1; i++)
         @(posedge clk);
      repeat (2) @(posedge clk);
      check({11'h0, serial_tx_out}, 12'h0);
      wr(4'h8, 12'h0a5);
      @(posedge clk);
      check({10'h0, wr_refused, tx_buffer_empty_flag}, 12'h3);
      break_request_bit <= 1'h0;
      repeat (3) @(posedge clk);
      check({11'h0, serial_tx_out}, 12'h1);
      wr(4'h8, 12'h03c);
      request_to_send_ctrl <= 1'h0;
      repeat (4) @(posedge clk);
      check({11'h0, rts_n}, 12'h0);
      repeat (200) @(posedge clk);
      check({10'h0, rts_n, serial_tx_out}, 12'h3);
      $display("break test done");
      final_report();
   end
endmodule
